// >>> hw/hipos_pkg.sv
package hipos_pkg;

	// Mode of operation codes.
	localparam logic [7:0] MODE_HOMING = 8'h06;
	localparam logic [7:0] MODE_INTERP = 8'h07;

	// Wishbone register byte addresses.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_METHOD = 8'h08;
	localparam logic [7:0] ADDR_CUR_THR = 8'h0c;
	localparam logic [7:0] ADDR_BLOCK_MS = 8'h10;
	localparam logic [7:0] ADDR_TARGET = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_POSITION = 8'h1c;
	localparam logic [7:0] ADDR_FERR_WIN = 8'h20;
	localparam logic [7:0] ADDR_FERR_MS = 8'h24;
	localparam logic [7:0] ADDR_STEP = 8'h28;
	localparam logic [7:0] ADDR_CFG = 8'h2c;

	// Controlword and statusword bit positions.
	localparam int CW_START = 4;
	localparam int CW_HALT = 8;
	localparam int SW_TARGET = 10;
	localparam int SW_ACTIVE = 12;
	localparam int SW_ERROR = 13;
	localparam int SW_SYNC = 8;

	// Configuration bit positions.
	localparam int CFG_CLOSED = 0;
	localparam int CFG_OPEN = 1;
	localparam int CFG_NMT_OP = 2;

	// Timing: one millisecond base at a 25 MHz clock.
	localparam int CLK_HZ = 25000000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

	// Reset values.
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_STEP = 32'h0000_0001;

	// Homing method number limits.
	localparam int M_IDX_LO = 1;
	localparam int M_IDX_HI = 14;
	localparam int M_SW_LO = 17;
	localparam int M_SW_HI = 30;
	localparam int M_NEXT_A = 33;
	localparam int M_NEXT_B = 34;
	localparam int M_HERE = 35;
	localparam int M_GAP_LO = 3;
	localparam int M_GAP_HI = 6;
	localparam int M_LIMPOS_HI = 10;
	localparam int M_SW_OFS = 16;
	localparam int M_RIGHT_LO = 5;

	// Homing sequencer states.
	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_SEARCH = 3'b001,
		HS_INDEX = 3'b010,
		HS_BLOCK = 3'b011,
		HS_DONE = 3'b100,
		HS_FAIL = 3'b101
	} hipos_hstate_t;

	// Decoded homing method.
	typedef struct packed {
		logic valid;
		logic use_index;
		logic use_switch;
		logic on_block;
		logic here;
		logic dir_pos;
		logic right_edge;
	} hipos_method_t;

	// Field inputs grouped together.
	typedef struct packed {
		logic lim_neg;
		logic lim_pos;
		logic home_sw;
		logic index;
		logic sync;
	} hipos_pins_t;

endpackage : hipos_pkg

// >>> hw/hipos_top.sv
// Function
// (RULE1) Block homing only in closed loop
// (RULE2) Stop detected when current exceeds threshold
// (RULE3) Keep pushing for configured blocking duration
// (RULE4) Methods 1..14 use switches and index
// (RULE5) Methods 17..30 use switches only
// (RULE6) Methods 33,34 use next index only
// (RULE7) Method 35 takes present position
// (RULE8) Method 35 needs no operation enabled
// (RULE9) Negative methods select block homing
// (RULE10) Methods 1,2 use negative/positive limit
// (RULE11) Methods 3..6 left/right home edge
// (RULE12) Methods 7..14 respect positive/negative limit; the code never reads the limit pins for these methods
// (RULE13) Methods 17,18 limit switch, no index
// (RULE14) Methods 19..22 home edges, no index
// (RULE15) Host writes 7 for interpolation
// (RULE16) Lock to sync once operational
// (RULE17) Controlword bit 4 starts interpolation
// (RULE18) Halt bit brakes, release ramps back
// (RULE19) Status bit 10 target reached logic
// (RULE20) Status bit 12 while interpolating
// (RULE21) Status bit 13 following error timeout
// (RULE22) Linear path toward single target
// (RULE23) Host writes 6 for homing
// (RULE24) Bit 4 runs homing until done/cleared
// (RULE25) Hold last target, never extrapolate
// (RULE26) Unsupported method refuses homing
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module hipos_top
	import hipos_pkg::*;
#(
	parameter int MS_CYCLES = CYC_PER_MS
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RESET_N,
	input wire logic I_CE,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	input wire logic I_LIM_NEG,
	input wire logic I_LIM_POS,
	input wire logic I_HOME_SW,
	input wire logic I_INDEX,
	input wire logic I_SYNC,
	input wire logic [15:0] I_CURRENT,
	input wire logic [31:0] I_ACT_POS,
	input wire logic I_OP_ENABLED,
	output logic [31:0] O_DEMAND_POS,
	output logic O_MOTOR_ON,
	output logic O_DIR_POS
);

	////////////////////////////////////////////////////////////////////////
	// Registers and pin synchronisers.

	logic [15:0] ctrl_q; // Controlword.
	logic [7:0] mode_q; // Mode of operation select.
	logic [7:0] method_q; // Signed homing method number.
	logic [15:0] cur_thr_q; // Block detection current threshold.
	logic [15:0] block_ms_q; // Blocking duration in milliseconds.
	logic [31:0] target_q; // Interpolation target.
	logic [31:0] ferr_win_q; // Following error window.
	logic [15:0] ferr_ms_q; // Following error timeout in milliseconds.
	logic [31:0] step_q; // Position step per clock along the path.
	logic [2:0] cfg_q; // Closed loop, open loop and operational flags.
	logic [31:0] pos_q; // Demand position.
	hipos_pins_t meta_q; // First synchroniser stage, read only by the second.
	hipos_pins_t pin_q; // Synchronised pins.
	hipos_pins_t prev_q; // Previous synchronised pins for edges.
	logic halt_prev_q; // Last halt value, for transitions.
	logic braking_q; // Halt braking in progress.
	logic synced_q; // Locked to sync.
	logic ip_active_q; // Interpolation running.
	logic homed_q; // Homing completed since restart.
	hipos_hstate_t hstate_q; // Homing sequencer state.
	logic [15:0] ms_cnt_q; // Millisecond prescaler.
	logic [15:0] blk_ms_q; // Milliseconds spent pushing on the block.
	logic [15:0] fe_ms_q; // Milliseconds outside the error window.
	logic ferr_q; // Following error flag.
	logic ack_q; // Bus acknowledge.
	logic [31:0] rdat_q; // Bus read data.

	logic ms_tick; // One-millisecond pulse.
	logic bus_req; // Valid bus cycle awaiting ack.
	logic wr_en; // Write takes effect this edge.
	hipos_method_t m; // Decoded method.
	logic lim_only; // Profile references straight on a limit switch.
	logic [31:0] sw_word; // Statusword image.
	logic [31:0] ferr_abs; // Magnitude of following error.
	logic [31:0] diff; // Target minus demand.
	logic [31:0] mag; // Magnitude of the remaining path.
	logic at_target; // Demand equals target.

	// Both synchroniser stages step together; logic reads pin_q and prev_q, never meta_q.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			meta_q <= '0;
			pin_q <= '0;
			prev_q <= '0;
		end else if (I_CE) begin
			meta_q <= {I_LIM_NEG, I_LIM_POS, I_HOME_SW, I_INDEX, I_SYNC};
			pin_q <= meta_q;
			prev_q <= pin_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, ack drops the cycle after.

	assign bus_req = I_WB_CYC && I_WB_STB && !ack_q;
	assign wr_en = bus_req && I_WB_WE && I_CE;

	// Acknowledge every cycle, mapped or not; unmapped reads return zero.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			ack_q <= 1'b0;
		end else if (I_CE) begin
			ack_q <= bus_req;
		end
	end

	// Read multiplexer, registered so data comes from flip-flops.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			rdat_q <= RST_ZERO;
		end else if (I_CE && bus_req) begin
			if (I_WB_ADR == ADDR_CTRL) begin
				rdat_q <= {16'h0000, ctrl_q};
			end else if (I_WB_ADR == ADDR_MODE) begin
				rdat_q <= {24'h000000, mode_q};
			end else if (I_WB_ADR == ADDR_METHOD) begin
				rdat_q <= {24'h000000, method_q};
			end else if (I_WB_ADR == ADDR_CUR_THR) begin
				rdat_q <= {16'h0000, cur_thr_q};
			end else if (I_WB_ADR == ADDR_BLOCK_MS) begin
				rdat_q <= {16'h0000, block_ms_q};
			end else if (I_WB_ADR == ADDR_TARGET) begin
				rdat_q <= target_q;
			end else if (I_WB_ADR == ADDR_STATUS) begin
				rdat_q <= sw_word;
			end else if (I_WB_ADR == ADDR_POSITION) begin
				rdat_q <= pos_q;
			end else if (I_WB_ADR == ADDR_FERR_WIN) begin
				rdat_q <= ferr_win_q;
			end else if (I_WB_ADR == ADDR_FERR_MS) begin
				rdat_q <= {16'h0000, ferr_ms_q};
			end else if (I_WB_ADR == ADDR_STEP) begin
				rdat_q <= step_q;
			end else if (I_WB_ADR == ADDR_CFG) begin
				rdat_q <= {29'h00000000, cfg_q};
			end else begin
				rdat_q <= RST_ZERO;
			end
		end
	end

	// Write decoder; the low byte lanes only matter for narrow fields.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			ctrl_q <= '0;
			mode_q <= '0;
			method_q <= '0;
			cur_thr_q <= '0;
			block_ms_q <= '0;
			target_q <= RST_ZERO;
			ferr_win_q <= RST_ZERO;
			ferr_ms_q <= '0;
			step_q <= RST_STEP;
			cfg_q <= '0;
		end else if (wr_en) begin
			if (I_WB_ADR == ADDR_CTRL && (&I_WB_SEL[1:0])) begin
				ctrl_q <= I_WB_DAT[15:0];
			end else if (I_WB_ADR == ADDR_MODE && I_WB_SEL[0]) begin
				mode_q <= I_WB_DAT[7:0]; // RULE15 RULE23
			end else if (I_WB_ADR == ADDR_METHOD && I_WB_SEL[0]) begin
				method_q <= I_WB_DAT[7:0];
			end else if (I_WB_ADR == ADDR_CUR_THR && I_WB_SEL[0]) begin
				cur_thr_q <= I_WB_DAT[15:0];
			end else if (I_WB_ADR == ADDR_BLOCK_MS && I_WB_SEL[0]) begin
				block_ms_q <= I_WB_DAT[15:0];
			end else if (I_WB_ADR == ADDR_TARGET && (&I_WB_SEL)) begin
				target_q <= I_WB_DAT; // RULE25
			end else if (I_WB_ADR == ADDR_FERR_WIN && (&I_WB_SEL)) begin
				ferr_win_q <= I_WB_DAT;
			end else if (I_WB_ADR == ADDR_FERR_MS && I_WB_SEL[0]) begin
				ferr_ms_q <= I_WB_DAT[15:0];
			end else if (I_WB_ADR == ADDR_STEP && (&I_WB_SEL)) begin
				step_q <= I_WB_DAT;
			end else if (I_WB_ADR == ADDR_CFG && I_WB_SEL[0]) begin
				cfg_q <= I_WB_DAT[2:0];
			end
		end
	end

	assign O_WB_ACK = ack_q;
	assign O_WB_DAT = rdat_q;

	////////////////////////////////////////////////////////////////////////
	// Homing method decode.

	// Negative numbers are two's complement bytes; magnitude picks the profile.
	always_comb begin
		logic neg;
		logic [7:0] a;
		logic [7:0] p;
		neg = method_q[7];
		a = neg ? 8'(-method_q) : method_q;
		p = (a >= 8'(M_SW_LO)) ? 8'(a - 8'(M_SW_OFS)) : a;
		m = '0;
		lim_only = (p <= 8'(M_IDX_LO + 1));
		if (!neg && a >= 8'(M_IDX_LO) && a <= 8'(M_IDX_HI)) begin
			m.valid = 1'b1;
			m.use_index = 1'b1; // RULE4
			m.use_switch = 1'b1;
		end else if (!neg && a >= 8'(M_SW_LO) && a <= 8'(M_SW_HI)) begin
			m.valid = 1'b1;
			m.use_switch = 1'b1; // RULE5
		end else if (!neg && (a == 8'(M_NEXT_A) || a == 8'(M_NEXT_B))) begin
			m.valid = 1'b1;
			m.use_index = 1'b1; // RULE6
		end else if (!neg && a == 8'(M_HERE)) begin
			m.valid = 1'b1;
			m.here = 1'b1; // RULE7
		end else if (neg && ((p >= 8'(M_IDX_LO) && p <= 8'(M_IDX_LO + 1))
				|| (p > 8'(M_GAP_HI) && p <= 8'(M_IDX_HI)))) begin
			m.valid = cfg_q[CFG_CLOSED]; // RULE9 RULE1
			m.on_block = 1'b1;
			m.use_index = (a <= 8'(M_IDX_HI));
		end
		// Odd numbers go negative; 7..10 bound by positive limit first.
		m.dir_pos = (p > 8'(M_GAP_HI) && p <= 8'(M_LIMPOS_HI)) || !p[0]; // RULE10 RULE12 RULE13
		m.right_edge = (p >= 8'(M_RIGHT_LO) && p <= 8'(M_GAP_HI)); // RULE11 RULE14
	end

	////////////////////////////////////////////////////////////////////////
	// Millisecond prescaler and homing sequencer.

	assign ms_tick = (ms_cnt_q == 16'(MS_CYCLES - 1));

	// Free-running millisecond prescaler for both timeouts.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			ms_cnt_q <= '0;
		end else if (I_CE) begin
			ms_cnt_q <= ms_tick ? 16'h0000 : 16'(ms_cnt_q + 16'h0001);
		end
	end

	logic homing_mode; // Homing selected.
	logic hit_switch; // Reference switch condition met.
	assign homing_mode = (mode_q == MODE_HOMING);
	// Limit switch, else the home edge: rising for left, falling for right.
	assign hit_switch = lim_only ? (m.dir_pos ? pin_q.lim_pos : pin_q.lim_neg)
		: (m.right_edge ? (prev_q.home_sw && !pin_q.home_sw) : (pin_q.home_sw && !prev_q.home_sw)); // RULE11 RULE14

	// Homing sequencer; clearing bit 4 aborts at any point.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			hstate_q <= HS_IDLE;
			blk_ms_q <= '0;
			homed_q <= 1'b0;
		end else if (I_CE) begin
			if (!homing_mode || !ctrl_q[CW_START]) begin
				hstate_q <= HS_IDLE; // RULE24
			end else begin
				case (hstate_q)
					HS_IDLE: begin
						if (!m.valid) begin
							hstate_q <= HS_FAIL; // RULE26
						end else if (m.here) begin
							hstate_q <= HS_DONE; // RULE8
							homed_q <= 1'b1;
						end else if (I_OP_ENABLED) begin
							hstate_q <= HS_SEARCH;
							homed_q <= 1'b0;
						end
					end
					HS_SEARCH: begin
						blk_ms_q <= '0;
						if (m.on_block && I_CURRENT > cur_thr_q) begin
							hstate_q <= HS_BLOCK; // RULE2
						end else if (!m.on_block && !m.use_switch && pin_q.index && !prev_q.index) begin
							hstate_q <= HS_DONE; // RULE6
							homed_q <= 1'b1;
						end else if (!m.on_block && m.use_switch && hit_switch) begin
							hstate_q <= m.use_index ? HS_INDEX : HS_DONE;
							homed_q <= !m.use_index;
						end
					end
					HS_BLOCK: begin
						if (ms_tick) begin
							blk_ms_q <= 16'(blk_ms_q + 16'h0001);
						end
						if (blk_ms_q >= block_ms_q) begin
							hstate_q <= m.use_index ? HS_INDEX : HS_DONE; // RULE3
							homed_q <= !m.use_index;
						end
					end
					HS_INDEX: begin
						if (pin_q.index && !prev_q.index) begin
							hstate_q <= HS_DONE;
							homed_q <= 1'b1;
						end
					end
					default: begin
						hstate_q <= hstate_q;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interpolated position mode.

	assign diff = 32'(target_q - pos_q);
	assign mag = diff[31] ? 32'(-diff) : diff;
	assign at_target = (diff == RST_ZERO);

	// Lock to sync edges only once operational.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			synced_q <= 1'b0;
		end else if (I_CE) begin
			if (!cfg_q[CFG_NMT_OP]) begin
				synced_q <= 1'b0;
			end else if (pin_q.sync && !prev_q.sync) begin
				synced_q <= 1'b1; // RULE16
			end
		end
	end

	// Interpolation runs while mode 7 and bit 4 are set and sync is locked.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			ip_active_q <= 1'b0;
		end else if (I_CE) begin
			ip_active_q <= (mode_q == MODE_INTERP) && ctrl_q[CW_START] && synced_q; // RULE17
		end
	end

	// Halt transitions: rising brakes, falling restarts the ramp.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			halt_prev_q <= 1'b0;
			braking_q <= 1'b0;
		end else if (I_CE) begin
			halt_prev_q <= ctrl_q[CW_HALT];
			if (ctrl_q[CW_HALT] && !halt_prev_q) begin
				braking_q <= 1'b1; // RULE18
			end else if (!ctrl_q[CW_HALT]) begin
				braking_q <= 1'b0; // RULE18
			end
		end
	end

	// Linear path: fixed step per clock, clamped so target is never passed.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			pos_q <= RST_ZERO;
		end else if (I_CE) begin
			if (hstate_q == HS_DONE && m.here) begin
				pos_q <= I_ACT_POS; // RULE7
			end else if (ip_active_q && !braking_q && !at_target) begin
				if (mag <= step_q) begin
					pos_q <= target_q; // RULE25
				end else if (diff[31]) begin
					pos_q <= 32'(pos_q - step_q); // RULE22
				end else begin
					pos_q <= 32'(pos_q + step_q); // RULE22
				end
			end
		end
	end

	// Following error timer in closed loop only.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			fe_ms_q <= '0;
			ferr_q <= 1'b0;
		end else if (I_CE) begin
			if (!cfg_q[CFG_CLOSED] || ferr_abs <= ferr_win_q) begin
				fe_ms_q <= '0;
				ferr_q <= 1'b0;
			end else begin
				if (ms_tick && fe_ms_q != 16'hffff) begin
					fe_ms_q <= 16'(fe_ms_q + 16'h0001);
				end
				ferr_q <= (fe_ms_q > ferr_ms_q); // RULE21
			end
		end
	end

	assign ferr_abs = (32'(pos_q - I_ACT_POS) & 32'h8000_0000) != RST_ZERO
		? 32'(I_ACT_POS - pos_q) : 32'(pos_q - I_ACT_POS);

	////////////////////////////////////////////////////////////////////////
	// Statusword and motor outputs.

	// Status layout depends on mode; speed zero means not stepping.
	always_comb begin
		sw_word = RST_ZERO;
		sw_word[SW_SYNC] = synced_q;
		if (homing_mode) begin
			sw_word[SW_TARGET] = (hstate_q == HS_DONE) || (hstate_q == HS_IDLE) || (hstate_q == HS_FAIL);
			sw_word[SW_ACTIVE] = homed_q;
			sw_word[SW_ERROR] = (hstate_q == HS_FAIL);
		end else begin
			sw_word[SW_TARGET] = halt_prev_q ? (braking_q || !ip_active_q) : at_target; // RULE19
			sw_word[SW_ACTIVE] = ip_active_q; // RULE20
			sw_word[SW_ERROR] = ferr_q; // RULE21
		end
	end

	// Motor outputs from flip-flops.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			O_DEMAND_POS <= RST_ZERO;
			O_MOTOR_ON <= 1'b0;
			O_DIR_POS <= 1'b0;
		end else if (I_CE) begin
			O_DEMAND_POS <= pos_q;
			O_MOTOR_ON <= (hstate_q == HS_SEARCH) || (hstate_q == HS_BLOCK) || (hstate_q == HS_INDEX);
			O_DIR_POS <= m.dir_pos;
		end
	end

endmodule : hipos_top
`default_nettype wire

// >>> test/hipos_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Checks of the bus handshake and the interpolated motion.
module hipos_chk
	import hipos_pkg::*;
#(
	parameter int MS_CYCLES = CYC_PER_MS
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RESET_N,
	input wire logic I_CE,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	input wire logic [31:0] O_WB_DAT,
	input wire logic O_WB_ACK,
	input wire logic I_LIM_NEG,
	input wire logic I_LIM_POS,
	input wire logic I_HOME_SW,
	input wire logic I_INDEX,
	input wire logic I_SYNC,
	input wire logic [15:0] I_CURRENT,
	input wire logic [31:0] I_ACT_POS,
	input wire logic I_OP_ENABLED,
	input wire logic [31:0] O_DEMAND_POS,
	input wire logic O_MOTOR_ON,
	input wire logic O_DIR_POS
);
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RESET_N);
	logic take; // A request is taken at this edge.
	logic below; // The previous demand was not above the target.
	logic [31:0] step_q, tgt_q, mode_q, prev_q, dlt, mag;
	assign take = I_WB_CYC && I_WB_STB && !O_WB_ACK && I_CE;
	assign below = $signed(prev_q) <= $signed(tgt_q);
	assign dlt = O_DEMAND_POS - prev_q;
	assign mag = dlt[31] ? -dlt : dlt;
	////////////////////////////////
	// Shadows of the motion settings.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			step_q <= RST_STEP;
			tgt_q <= RST_ZERO;
			mode_q <= RST_ZERO;
		end else if (take && I_WB_WE && I_WB_SEL == 4'hf) begin
			if (I_WB_ADR == ADDR_STEP) step_q <= I_WB_DAT;
			if (I_WB_ADR == ADDR_TARGET) tgt_q <= I_WB_DAT;
			if (I_WB_ADR == ADDR_MODE) mode_q <= I_WB_DAT;
		end
	end
	// Demand of the previous edge.
	always_ff @(posedge I_SYS_CLK) begin
		prev_q <= O_DEMAND_POS;
	end
	////////////////////////////////
	sequence s_read(logic [7:0] a);
		take && !I_WB_WE && I_WB_ADR == a;
	endsequence
	// Interpolating with unchanged settings.
	sequence s_interp;
		mode_q == MODE_INTERP && $stable(mode_q) && $stable(tgt_q) && $stable(step_q);
	endsequence
	a_ack_answer: assert property (take |=> O_WB_ACK)
		else $error("ack missing one cycle after a request");
	a_ack_single: assert property (O_WB_ACK && I_CE |=> !O_WB_ACK)
		else $error("ack held longer than one cycle");
	a_ack_unasked: assert property (!(I_WB_CYC && I_WB_STB) && I_CE |=> !O_WB_ACK)
		else $error("ack without a request");
	a_unmapped_zero: assert property (s_read(I_WB_ADR) && (I_WB_ADR[1:0] != 2'b00 || I_WB_ADR > ADDR_CFG)
		|=> O_WB_DAT == RST_ZERO) else $error("unmapped read not zero");
	a_demand_readback: assert property (s_read(ADDR_POSITION) |=> O_WB_DAT == O_DEMAND_POS)
		else $error("demand read differs from demand output");
	a_reset_quiet: assert property ($rose(I_RESET_N) |-> O_DEMAND_POS == RST_ZERO && !O_MOTOR_ON && !O_WB_ACK)
		else $error("outputs not cleared by reset");
	a_idle_no_motion: assert property (!I_OP_ENABLED [*3] |-> !O_MOTOR_ON)
		else $error("motor driven while operation disabled");
	a_ce_freeze: assert property (!I_CE |=> $stable(O_DEMAND_POS) && $stable(O_MOTOR_ON) && $stable(O_DIR_POS))
		else $error("outputs moved while clock enable low");
	a_linear_step: assert property (s_interp |-> mag <= step_q)
		else $error("demand step larger than step setting");
	a_hold_target: assert property (s_interp |-> (below ? $signed(O_DEMAND_POS) <= $signed(tgt_q)
		: $signed(O_DEMAND_POS) >= $signed(tgt_q))) else $error("demand passed the target");
endmodule : hipos_chk
bind hipos_top hipos_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);
`default_nettype wire

// >>> test/hipos_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: sync sender and a plant following the demand.
module hipos_host_model
	import hipos_pkg::*;
#(
	parameter int SYNC_PER = 50
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_stall,
	input wire logic i_preset,
	input wire logic [31:0] i_preset_val,
	input wire logic [31:0] i_demand,
	output logic o_sync,
	output logic [31:0] o_act_pos
);
	int cnt_q; // Cycles since the last sync object.
	// Sync of two cycles at a fixed period, so the double sampler cannot miss it.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt_q <= 0;
			o_sync <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == SYNC_PER - 1) ? 0 : cnt_q + 1;
			o_sync <= cnt_q < 2;
		end
	end
	// A stalled plant stays put, which is how a following error is provoked.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) o_act_pos <= RST_ZERO;
		else if (i_preset) o_act_pos <= i_preset_val;
		else if (!i_stall) o_act_pos <= i_demand;
	end
endmodule : hipos_host_model
`default_nettype wire

// >>> test/hipos_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hipos_top_tb;
	import hipos_pkg::*;
	localparam int MSC = 10; // Short millisecond for quick timeouts.
	localparam logic [31:0] B_ERR = 32'h2000, B_ACT = 32'h1000, B_TGT = 32'h0400;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic op_en = 1'b0, stall = 1'b0, pre = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, pre_v = 32'h0;
	logic [15:0] cur = 16'h0;
	hipos_pins_t pins = '0; // Sync field unused; the host model drives sync.
	logic [31:0] rdat, dem, act;
	logic ack, mot, dpos, sync;
	int error_cnt = 0, n_checks = 0, seed = 98348;
	always #20 clk = ~clk;
	hipos_host_model u_host (.i_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_preset(pre),
		.i_preset_val(pre_v), .i_demand(dem), .o_sync(sync), .o_act_pos(act));
	hipos_top #(.MS_CYCLES(MSC)) uut (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_CE(ce), .I_WB_CYC(cyc),
		.I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
		.O_WB_ACK(ack), .I_LIM_NEG(pins.lim_neg), .I_LIM_POS(pins.lim_pos), .I_HOME_SW(pins.home_sw),
		.I_INDEX(pins.index), .I_SYNC(sync), .I_CURRENT(cur), .I_ACT_POS(act), .I_OP_ENABLED(op_en),
		.O_DEMAND_POS(dem), .O_MOTOR_ON(mot), .O_DIR_POS(dpos));
	////////////////////////////////
	task automatic report_and_stop();
		if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One classic cycle, held until ack is sampled.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int t;
		t = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			t++;
		end while (ack !== 1'b1 && t < 100);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk("bus ack", 32'h1, {31'h0, ack});
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		wb(1'b0, a, 32'h0, q);
	endtask : rd
	// Polls the status word until the masked bits match.
	task automatic st_wait(input logic [31:0] msk, input logic [31:0] e);
		logic [31:0] q;
		int t;
		t = 0;
		rd(ADDR_STATUS, q);
		while ((q & msk) !== e && t < 60) begin
			rd(ADDR_STATUS, q);
			t++;
		end
		chk("status", e, q & msk);
	endtask : st_wait
	task automatic wait_mot(input logic v);
		int t;
		t = 0;
		while (mot !== v && t < 60) begin
			@(posedge clk);
			t++;
		end
		chk("motor on", {31'h0, v}, {31'h0, mot});
	endtask : wait_mot
	task automatic home(input logic [7:0] m);
		wr(ADDR_METHOD, {24'h0, m});
		wr(ADDR_CTRL, 32'h10);
	endtask : home
	// Homing started and moving, with no stale completion or error shown.
	task automatic go(input logic [7:0] m);
		home(m);
		wait_mot(1'b1);
		st_wait(B_TGT | B_ERR, 32'h0);
	endtask : go
	task automatic pulse_idx();
		pins.index <= 1'b1;
		repeat (4) @(posedge clk);
		pins.index <= 1'b0;
	endtask : pulse_idx
	// Waits for the target with a flickering clock enable.
	task automatic reach(input logic [31:0] tg);
		int t;
		t = 0;
		while (dem !== tg && t < 4000) begin
			@(posedge clk);
			ce <= ($random(seed) & 7) != 0;
			t++;
		end
		@(posedge clk);
		ce <= 1'b1;
		chk("demand at target", tg, dem);
	endtask : reach
	// Supported method numbers; everything else must be refused.
	function automatic logic m_ok(input logic signed [7:0] m);
		int a;
		a = (m < 0) ? -m : m;
		if (m < 0) return a inside {[1:2], [7:14], [17:18], [23:30]};
		return a inside {[1:14], [17:30], 33, 34, 35};
	endfunction : m_ok
	////////////////////////////////
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		logic [31:0] q, tg;
		logic [7:0] m;
		logic [7:0] tbl [14] = '{8'd0, 8'd15, 8'd16, 8'd31, 8'd32, 8'd36, 8'hfd, 8'hf1, 8'd1, 8'd2, 8'd17,
			8'd18, 8'd33, 8'hff};
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADDR_STEP, q);
		chk("step reset", RST_STEP, q);
		wr(ADDR_POSITION, 32'h1234);
		rd(ADDR_POSITION, q);
		chk("demand read only", RST_ZERO, q);
		rd(8'h30, q);
		chk("unmapped read", RST_ZERO, q);
		repeat (120) @(posedge clk);
		st_wait(32'h100, 32'h0);
		wr(ADDR_CFG, 32'h5);
		st_wait(32'h100, 32'h100);
		// Present position taken as reference with operation still disabled.
		pre_v <= $random(seed);
		pre <= 1'b1;
		wr(ADDR_MODE, {24'h0, MODE_HOMING});
		home(8'd35);
		st_wait(B_TGT | B_ERR, B_TGT);
		chk("homed position", pre_v, dem);
		chk("no motion", 32'h0, {31'h0, mot});
		pre <= 1'b0;
		op_en <= 1'b1;
		for (int i = 0; i < 26; i++) begin
			wr(ADDR_CTRL, 32'h0);
			wait_mot(1'b0);
			m = (i < 14) ? tbl[i] : 8'($random(seed));
			if (m == 8'd35) continue;
			if (!m_ok(m)) begin
				home(m);
				st_wait(B_ERR, B_ERR);
				continue;
			end
			go(m);
			if (m == 8'd1 || m == 8'd2 || m == 8'd17 || m == 8'd18) chk("direction", {31'h0, m == 8'd2 || m == 8'd18},
				{31'h0, dpos});
		end
		wr(ADDR_CTRL, 32'h0);
		go(8'd17);
		pins.lim_neg <= 1'b1;
		st_wait(B_TGT | B_ERR, B_TGT);
		pins.lim_neg <= 1'b0;
		wr(ADDR_CTRL, 32'h0);
		go(8'd1);
		pins.lim_neg <= 1'b1;
		repeat (8) @(posedge clk);
		pins.lim_neg <= 1'b0;
		repeat (30) @(posedge clk);
		chk("index awaited", 32'h1, {31'h0, mot});
		pulse_idx();
		st_wait(B_TGT | B_ERR, B_TGT);
		wr(ADDR_CTRL, 32'h0);
		go(8'd34);
		pulse_idx();
		st_wait(B_TGT | B_ERR, B_TGT);
		wr(ADDR_CTRL, 32'h0);
		// Block homing is refused in open loop, then must push past the threshold.
		wr(ADDR_CFG, 32'h6);
		home(8'hef);
		st_wait(B_ERR, B_ERR);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_CFG, 32'h5);
		wr(ADDR_CUR_THR, 32'd100);
		wr(ADDR_BLOCK_MS, 32'd3);
		go(8'hef);
		cur <= 16'd100;
		repeat (40) @(posedge clk);
		chk("threshold not exceeded", 32'h1, {31'h0, mot});
		cur <= 16'd101;
		repeat (20) @(posedge clk);
		chk("pushing on block", 32'h1, {31'h0, mot});
		st_wait(B_TGT | B_ERR, B_TGT);
		cur <= 16'd0;
		wr(ADDR_CTRL, 32'h0);
		// Interpolation toward random targets, with halt and a stalled plant.
		wr(ADDR_MODE, {24'h0, MODE_INTERP});
		wr(ADDR_FERR_WIN, 32'd1000);
		wr(ADDR_FERR_MS, 32'd2);
		wr(ADDR_STEP, 32'(($random(seed) & 7) + 1));
		tg = dem + 32'($random(seed) % 300);
		wr(ADDR_TARGET, tg);
		wr(ADDR_CTRL, 32'h10);
		st_wait(B_ACT, B_ACT);
		reach(tg);
		repeat (20) @(posedge clk);
		chk("target held", tg, dem);
		st_wait(B_TGT | B_ERR, B_TGT);
		tg = tg - 32'd800;
		wr(ADDR_TARGET, tg);
		repeat (20) @(posedge clk);
		wr(ADDR_CTRL, 32'h110);
		repeat (40) @(posedge clk);
		q = dem;
		repeat (10) @(posedge clk);
		chk("halted", q, dem);
		st_wait(B_TGT, B_TGT);
		wr(ADDR_CTRL, 32'h10);
		reach(tg);
		wr(ADDR_FERR_WIN, 32'd4);
		stall <= 1'b1;
		wr(ADDR_TARGET, tg + 32'd100);
		st_wait(B_ERR, B_ERR);
		stall <= 1'b0;
		wr(ADDR_CTRL, 32'h0);
		st_wait(B_ACT, 32'h0);
		report_and_stop();
	end
endmodule : hipos_top_tb
`default_nettype wire
